/* File: logic/pcr_defs.svh */
// register offsets, field positions, reset values and timing for the config slice
// assumes inclusion by bare name from the design files
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH
`define PCR_HRV_ADDR        8'h19
`define PCR_MON_ADDR        8'h1A
`define PCR_BUCK_ADDR       8'h1B
`define PCR_HRV_ROOM_HI     3
`define PCR_HRV_ROOM_LO     2
`define PCR_HRV_COOL_HI     1
`define PCR_HRV_COOL_LO     0
`define PCR_MON_RATIO_HI    6
`define PCR_MON_RATIO_LO    5
`define PCR_MON_OFF_BIT     4
`define PCR_MON_CH_HI       3
`define PCR_MON_CH_LO       0
`define PCR_SEQ_HI          7
`define PCR_SEQ_LO          5
`define PCR_SWEN_HI         1
`define PCR_SWEN_LO         0
`define PCR_HRV_RESET       8'h00
`define PCR_MON_RESET       8'h00
`define PCR_SWEN_RESET      2'h0
`define PCR_BOOT_DELAY_US   1000
`define PCR_CLK_MHZ         200
`define PCR_BOOT_CYCLES     (`PCR_BOOT_DELAY_US * `PCR_CLK_MHZ)
`define PCR_STEP_MV         50
`endif

/* File: logic/pcr_pkg.sv */
// types shared by the config slice
// assumes pcr_defs.svh sits beside it
`default_nettype none
package pcr_pkg;
   typedef enum logic [2:0] {
      PCR_SEQ_OFF  = 3'h0,
      PCR_SEQ_R1   = 3'h1,
      PCR_SEQ_P0   = 3'h2,
      PCR_SEQ_P25  = 3'h3,
      PCR_SEQ_P50  = 3'h4,
      PCR_SEQ_R5   = 3'h5,
      PCR_SEQ_R6   = 3'h6,
      PCR_SEQ_SW   = 3'h7
   } pcr_seq_e;
   typedef enum logic [1:0] {
      PCR_SW_OFF = 2'h0,
      PCR_SW_ON  = 2'h1,
      PCR_SW_PIN = 2'h2,
      PCR_SW_RSV = 2'h3
   } pcr_swen_e;
   typedef enum logic [1:0] {
      PCR_ZONE_OTHER,
      PCR_ZONE_ROOM,
      PCR_ZONE_COOL
   } pcr_zone_e;
   typedef logic [7:0] pcr_byte_t;
endpackage
`default_nettype wire

/* File: logic/pcr_zone_adjust.sv */
// one zone reduction: maps a 2-bit code to a drop in 50 mV steps
// assumes the caller picks which zone code to feed in
`timescale 1ns/1ps
`include "pcr_defs.svh"
`default_nettype none
module pcr_zone_adjust (
   input  wire logic [1:0] code_i,
   output logic      [1:0] drop_steps_o
);
   // 00 -> 3 steps (150 mV), 11 -> no drop
   assign drop_steps_o = 2'h3 - code_i;
endmodule
`default_nettype wire

/* File: logic/pcr_config_regs.sv */
// register slice: harvester zone reductions, monitor mux setup, buck one enable
// assumes a simple synchronous register port on MCLK_I and a strap for the sequence code
`timescale 1ns/1ps
`include "pcr_defs.svh"
`default_nettype none
module pcr_config_regs #(
   parameter int unsigned BOOT_CYCLES = `PCR_BOOT_CYCLES
) (
   input  wire logic               MCLK_I,
   input  wire logic               ARST_N_I,
   input  wire logic               CE_I,
   input  wire logic               WR_EN_I,
   input  wire logic               RD_EN_I,
   input  wire logic [7:0]         ADDR_I,
   input  wire logic [7:0]         WDATA_I,
   output logic      [7:0]         RDATA_O,
   input  wire logic [2:0]         SEQ_STRAP_I,
   input  wire logic [3:0]         BASE_THRESHOLD_I,
   input  wire pcr_pkg::pcr_zone_e ZONE_I,
   input  wire logic               MPC_LEVEL_I,
   input  wire logic               HARD_OFF_I,
   input  wire logic [15:0]        MON_INPUTS_I,
   output logic      [3:0]         HRV_BASE_O,
   output logic      [1:0]         HRV_DROP_STEPS_O,
   output logic      [1:0]         MON_RATIO_O,
   output logic      [3:0]         MON_CHANNEL_O,
   output logic                    MON_OUT_O,
   output logic                    MON_OUT_OE_O,
   output logic                    MON_PULLDOWN_O,
   output logic                    BUCK_EN_O,
   output logic                    BUCK_ACT_DISCHARGE_O,
   output logic                    BOOT_DONE_O
);
   import pcr_pkg::*;

   pcr_byte_t      hrv_q;
   pcr_byte_t      mon_q;
   logic [1:0]     swen_q;
   logic [2:0]     seq_q;
   logic           strap_taken_q;
   logic [31:0]    boot_cnt_q;
   logic           boot_done_q;
   logic           buck_en_q;
   logic           dsc_q;
   logic [1:0]     room_steps;
   logic [1:0]     cool_steps;
   logic           buck_en_d;
   logic           dsc_d;
   pcr_seq_e       seq;

   assign seq = pcr_seq_e'(seq_q);

   // register writes; the sequence field is not writable
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         hrv_q  <= `PCR_HRV_RESET;
         mon_q  <= `PCR_MON_RESET;
         swen_q <= `PCR_SWEN_RESET;
      end else if (CE_I && WR_EN_I) begin
         case (ADDR_I)
            `PCR_HRV_ADDR:  hrv_q <= {4'h0, WDATA_I[3:0]};
            `PCR_MON_ADDR:  mon_q <= {1'b0, WDATA_I[6:0]};
            `PCR_BUCK_ADDR: swen_q <= WDATA_I[`PCR_SWEN_HI:`PCR_SWEN_LO];
            default: ;
         endcase
      end
   end

   // sequence code caught from the strap once after reset release
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         seq_q         <= 3'h0;
         strap_taken_q <= 1'b0;
      end else if (CE_I && !strap_taken_q) begin
         seq_q         <= SEQ_STRAP_I;
         strap_taken_q <= 1'b1;
      end
   end

   // boot delay counter
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         boot_cnt_q  <= 32'h0;
         boot_done_q <= 1'b0;
      end else if (CE_I && strap_taken_q && !boot_done_q) begin
         boot_cnt_q <= boot_cnt_q + 32'h1;
         if (boot_cnt_q + 32'h1 >= 32'(BOOT_CYCLES))
            boot_done_q <= 1'b1;
      end
   end

   // buck enable decision from sequence code and software field
   always_comb begin
      buck_en_d = 1'b0;
      dsc_d     = HARD_OFF_I;
      case (seq)
         PCR_SEQ_P0:  buck_en_d = strap_taken_q;
         PCR_SEQ_P25: buck_en_d = boot_cnt_q >= 32'(BOOT_CYCLES / 4) || boot_done_q;
         PCR_SEQ_P50: buck_en_d = boot_cnt_q >= 32'(BOOT_CYCLES / 2) || boot_done_q;
         PCR_SEQ_SW: begin
            if (boot_done_q) begin
               case (pcr_swen_e'(swen_q))
                  PCR_SW_ON:  buck_en_d = 1'b1;
                  PCR_SW_PIN: buck_en_d = MPC_LEVEL_I;
                  PCR_SW_OFF: buck_en_d = 1'b0;
                  default:    buck_en_d = 1'b0;
               endcase
            end
         end
         default: buck_en_d = 1'b0;
      endcase
      if (HARD_OFF_I)
         buck_en_d = 1'b0;
   end

   // registered buck outputs
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         buck_en_q <= 1'b0;
         dsc_q     <= 1'b1;
      end else if (CE_I) begin
         buck_en_q <= buck_en_d;
         dsc_q     <= dsc_d;
      end
   end

   // zone reductions from the two fields
   pcr_zone_adjust u_room (
      .code_i       (hrv_q[`PCR_HRV_ROOM_HI:`PCR_HRV_ROOM_LO]),
      .drop_steps_o (room_steps)
   );
   pcr_zone_adjust u_cool (
      .code_i       (hrv_q[`PCR_HRV_COOL_HI:`PCR_HRV_COOL_LO]),
      .drop_steps_o (cool_steps)
   );

   // harvester threshold outputs
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         HRV_BASE_O       <= 4'h0;
         HRV_DROP_STEPS_O <= 2'h0;
      end else if (CE_I) begin
         HRV_BASE_O <= BASE_THRESHOLD_I;
         case (ZONE_I)
            PCR_ZONE_ROOM: HRV_DROP_STEPS_O <= room_steps;
            PCR_ZONE_COOL: HRV_DROP_STEPS_O <= cool_steps;
            default:       HRV_DROP_STEPS_O <= 2'h0;
         endcase
      end
   end

   // monitor mux: channel zero means the mux is off
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         MON_OUT_O      <= 1'b0;
         MON_OUT_OE_O   <= 1'b0;
         MON_PULLDOWN_O <= 1'b0;
      end else if (CE_I) begin
         MON_OUT_O      <= MON_INPUTS_I[mon_q[`PCR_MON_CH_HI:`PCR_MON_CH_LO]];
         MON_OUT_OE_O   <= mon_q[`PCR_MON_CH_HI:`PCR_MON_CH_LO] != 4'h0;
         MON_PULLDOWN_O <= mon_q[`PCR_MON_CH_HI:`PCR_MON_CH_LO] == 4'h0 && !mon_q[`PCR_MON_OFF_BIT];
      end
   end

   // read data
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I)
         RDATA_O <= 8'h00;
      else if (CE_I && RD_EN_I) begin
         case (ADDR_I)
            `PCR_HRV_ADDR:  RDATA_O <= hrv_q;
            `PCR_MON_ADDR:  RDATA_O <= mon_q;
            `PCR_BUCK_ADDR: RDATA_O <= {seq_q, 3'h0, swen_q};
            default:        RDATA_O <= 8'h00;
         endcase
      end
   end

   assign MON_RATIO_O          = mon_q[`PCR_MON_RATIO_HI:`PCR_MON_RATIO_LO];
   assign MON_CHANNEL_O        = mon_q[`PCR_MON_CH_HI:`PCR_MON_CH_LO];
   assign BUCK_EN_O            = buck_en_q;
   assign BUCK_ACT_DISCHARGE_O = dsc_q;
   assign BOOT_DONE_O          = boot_done_q;

   // checks
   AST_SEQ_OFF: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      seq_q == 3'h0 |-> !BUCK_EN_O) else $error("buck on with sequence code off");
   AST_SW_IGNORED: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I && seq_q != 3'h7 && seq_q != 3'h2 && seq_q != 3'h3 && seq_q != 3'h4 |=> !BUCK_EN_O)
      else $error("software enable honoured outside code 111");
   AST_SW_ON: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I && seq_q == 3'h7 && boot_done_q && swen_q == 2'h1 && !HARD_OFF_I |=> BUCK_EN_O)
      else $error("software on not applied");
   AST_SW_OFF_NODSC: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I && !HARD_OFF_I |=> !BUCK_ACT_DISCHARGE_O) else $error("discharge outside hard off");
   AST_SEQ_RO: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      strap_taken_q |=> $stable(seq_q)) else $error("sequence code changed");
   AST_P0: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I && strap_taken_q && seq_q == 3'h2 && !HARD_OFF_I |=> BUCK_EN_O) else $error("code 010 not on");
   AST_RATIO: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I && WR_EN_I && ADDR_I == `PCR_MON_ADDR |=> MON_RATIO_O == $past(WDATA_I[6:5]))
      else $error("ratio not stored");
   AST_ROOM: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I && ZONE_I == PCR_ZONE_ROOM |=> HRV_DROP_STEPS_O == 2'h3 - $past(hrv_q[3:2]))
      else $error("room reduction wrong");
   AST_COOL: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I && ZONE_I == PCR_ZONE_COOL |=> HRV_DROP_STEPS_O == 2'h3 - $past(hrv_q[1:0]))
      else $error("cool reduction wrong");
   AST_BASE: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I |=> HRV_BASE_O == $past(BASE_THRESHOLD_I)) else $error("base threshold wrong");
   AST_MON_OE: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I && mon_q[3:0] == 4'h0 |=> !MON_OUT_OE_O) else $error("mux drives while off");
   AST_MON_SEL: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I |=> MON_OUT_O == $past(MON_INPUTS_I[mon_q[3:0]])) else $error("mux output not the selected input");
   AST_P25: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I && seq_q == 3'h3 && boot_cnt_q >= 32'(BOOT_CYCLES / 4) && !HARD_OFF_I |=> BUCK_EN_O)
      else $error("code 011 not on at quarter delay");
   AST_P50: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I && seq_q == 3'h4 && boot_cnt_q >= 32'(BOOT_CYCLES / 2) && !HARD_OFF_I |=> BUCK_EN_O)
      else $error("code 100 not on at half delay");
   AST_SW_WAIT: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      CE_I && seq_q == 3'h7 && !boot_done_q |=> !BUCK_EN_O) else $error("software control before boot delay");

   // frozen edge: clock enable low, then every writable field, the boot counter and buck enable hold
   sequence s_ce_low;
      !CE_I;
   endsequence
   sequence s_state_held;
      $stable(hrv_q) && $stable(mon_q) && $stable(swen_q) && $stable(boot_cnt_q) && $stable(BUCK_EN_O);
   endsequence
   AST_CE_FREEZE: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      s_ce_low |=> s_state_held) else $error("state moved while clock enable low");
endmodule
`default_nettype wire

/* File: test/pcr_config_regs_bench.sv */
// self-checking bench for the config register slice: random and corner register traffic
// assumes pcr_pkg is compiled first and the boot delay is shortened through BOOT_CYCLES
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module pcr_config_regs_bench;
   import pcr_pkg::*;
   localparam int unsigned BOOT = 40;
   logic        clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, mpc = 1'b0, hoff = 1'b0, ce = 1'b1;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, v;
   logic [2:0]  strap = 3'h7;
   logic [3:0]  base = 4'h0, hbase, ch;
   logic [1:0]  drop, ratio;
   logic [15:0] mins = 16'h0000, lf = 16'hBE80, r;
   logic        mout, moe, mpd, ben, bdis, bdone;
   logic [2:0]  seqs [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
   pcr_zone_e   zone = PCR_ZONE_OTHER;
   int          errors = 0, n_checks = 0, cyc = 0;
   // free running 200 MHz clock
   always #2.5 clk = ~clk;
   pcr_config_regs #(.BOOT_CYCLES(BOOT)) u_pcr_config_regs (
      .MCLK_I(clk), .ARST_N_I(rst_n), .CE_I(ce), .WR_EN_I(we), .RD_EN_I(re),
      .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .SEQ_STRAP_I(strap),
      .BASE_THRESHOLD_I(base), .ZONE_I(zone), .MPC_LEVEL_I(mpc), .HARD_OFF_I(hoff),
      .MON_INPUTS_I(mins), .HRV_BASE_O(hbase), .HRV_DROP_STEPS_O(drop),
      .MON_RATIO_O(ratio), .MON_CHANNEL_O(ch), .MON_OUT_O(mout), .MON_OUT_OE_O(moe),
      .MON_PULLDOWN_O(mpd), .BUCK_EN_O(ben), .BUCK_ACT_DISCHARGE_O(bdis), .BOOT_DONE_O(bdone)
   );
   // random source
   function automatic logic [15:0] nxt(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // code 00 drops three 50 mV steps, code 11 drops none
   function automatic logic [1:0] exp_drop(input logic [1:0] c);
      case (c)
         2'h0:    return 2'h3;
         2'h1:    return 2'h2;
         2'h2:    return 2'h1;
         default: return 2'h0;
      endcase
   endfunction
   // buck one level under software control
   function automatic logic exp_buck(input logic [1:0] s, input logic p, input logic h);
      return !h && (s == 2'h1 || (s == 2'h2 && p));
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      we = 1'b1;
      @(negedge clk);
      we = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      addr = a;
      re = 1'b1;
      @(negedge clk);
      re = 1'b0;
      v = rdata;
   endtask
   task automatic reset_to(input logic [2:0] s);
      @(negedge clk);
      rst_n = 1'b0;
      strap = s;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
   endtask
   task automatic wrap_up;
      if (errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         errors++;
         wrap_up();
      end
   end
   // main sequence
   initial begin
      reset_to(3'h7);
      rd(8'h19); `CHK(v, 8'h00)
      rd(8'h1A); `CHK(v, 8'h00)
      rd(8'h1B); `CHK(v, 8'hE0)
      `CHK(ben, 1'b0)
      repeat (BOOT + 5) @(negedge clk);
      `CHK(bdone, 1'b1)
      for (int i = 0; i < 8; i++) begin
         lf = nxt(lf);
         mpc = i[2];
         wr(8'h1B, {lf[7:2], i[1:0]});
         repeat (2) @(negedge clk);
         `CHK(ben, exp_buck(i[1:0], i[2], 1'b0))
         `CHK(bdis, 1'b0)
         rd(8'h1B); `CHK(v, {3'h7, 3'h0, i[1:0]})
      end
      wr(8'h1B, 8'h01);
      hoff = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(ben, 1'b0)
      `CHK(bdis, 1'b1)
      hoff = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(bdis, 1'b0)
      `CHK(ben, 1'b1)
      for (int i = 0; i < 20; i++) begin
         lf = nxt(lf);
         r = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : lf;
         base = r[11:8];
         zone = r[12] ? PCR_ZONE_ROOM : r[13] ? PCR_ZONE_COOL : PCR_ZONE_OTHER;
         mins = {r[7:0], r[15:8]};
         wr(8'h19, r[7:0]);
         wr(8'h1A, r[15:8]);
         repeat (2) @(negedge clk);
         `CHK(hbase, r[11:8])
         `CHK(drop, r[12] ? exp_drop(r[3:2]) : r[13] ? exp_drop(r[1:0]) : 2'h0)
         `CHK(ratio, r[14:13])
         `CHK(ch, r[11:8])
         `CHK(moe, (r[11:8] != 4'h0))
         `CHK(mpd, (r[11:8] == 4'h0 && !r[12]))
         if (r[11:8] != 4'h0) `CHK(mout, mins[r[11:8]])
         rd(8'h19); `CHK(v, {4'h0, r[3:0]})
         rd(8'h1A); `CHK(v, {1'b0, r[14:8]})
      end
      wr(8'h55, 8'hAA);
      rd(8'h55); `CHK(v, 8'h00)
      rd(8'h1B); `CHK(v, 8'hE1)
      // clock enable low: a write of code 00 must not land and buck one stays on
      ce = 1'b0;
      wr(8'h1B, 8'h00);
      repeat (2) @(negedge clk);
      `CHK(ben, 1'b1)
      ce = 1'b1;
      rd(8'h1B); `CHK(v, 8'hE1)
      foreach (seqs[k]) begin
         reset_to(seqs[k]);
         repeat (3) @(negedge clk);
         `CHK(ben, (seqs[k] == 3'h2))
         repeat (12) @(negedge clk);
         `CHK(ben, (seqs[k] == 3'h2 || seqs[k] == 3'h3))
         repeat (30) @(negedge clk);
         `CHK(ben, (seqs[k] inside {3'h2, 3'h3, 3'h4}))
         wr(8'h1B, 8'h01);
         repeat (2) @(negedge clk);
         `CHK(ben, (seqs[k] inside {3'h2, 3'h3, 3'h4}))
         rd(8'h1B); `CHK(v, {seqs[k], 5'h01})
      end
      wrap_up();
   end
endmodule
`default_nettype wire
